/* include/smx_pkg.sv */
// Constants and types shared by the serial channel selector
package smx_pkg;
  // Control word layout
  localparam int WORD_W = 4;
  localparam int IDX_W = 3;
  localparam int N_CHAN = 8;
  localparam int ON_BIT = 3;
  localparam int IDX_MSB = 2;
  // Reset values and the one-hot decode base
  localparam logic [WORD_W-1:0] SHREG_RST = 4'h0;
  localparam logic [N_CHAN-1:0] CHAN_RST = 8'h00;
  localparam logic CS_HI_RST = 1'b1;
  localparam logic [N_CHAN-1:0] CHAN_ONE = 8'h01;
  // Timing, nanoseconds and derived cycle counts
  localparam int CLK_NS = 8;
  localparam int TON_NS = 700;
  localparam int TURN_OFF_DELAY_NS = 300;
  localparam int TON_CYC = TON_NS / CLK_NS;
  localparam int TURN_OFF_DELAY_CYC = TURN_OFF_DELAY_NS / CLK_NS;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] TON_LOAD = CNT_W'(TON_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_OFF_DELAY_LOAD = CNT_W'(TURN_OFF_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  // Switch sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BREAK = 2'b01,
    ST_MAKE = 2'b10,
    ST_ON = 2'b11
  } smx_state_t;
endpackage

/* include/smx_word_if.sv */
// Valid/ready carrier for one control word
`timescale 1ns/1ps
`default_nettype none
interface smx_word_if;
  logic valid;
  logic ready;
  logic [smx_pkg::WORD_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* verilog/smx_sync3.sv */
// Three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ps
`default_nettype none
module smx_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clocking
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // Pin and results
  input wire logic pin_i,
  output logic level_q,
  output logic rise_q,
  output logic fall_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  assign level_d = (s2_q == s3_q) ? s2_q : level_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      rise_q <= level_d & ~level_q;
      fall_q <= ~level_d & level_q;
    end
  end
endmodule // smx_sync3
`default_nettype wire

/* verilog/smx_fifo2.sv */
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smx_fifo2 (
  // Clocking
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // Fill and drain sides
  smx_word_if.snk in_w,
  smx_word_if.src out_w
);
  import smx_pkg::*;
  logic [WORD_W-1:0] slot_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_w.ready = (cnt_q != 2'h2);
  assign out_w.valid = (cnt_q != 2'h0);
  assign out_w.data = slot_q[rd_q];
  assign push = clk_en & in_w.valid & in_w.ready;
  assign pop = clk_en & out_w.valid & out_w.ready;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slot_q[0] <= SHREG_RST;
      slot_q[1] <= SHREG_RST;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        slot_q[wr_q] <= in_w.data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // smx_fifo2
`default_nettype wire

/* verilog/smx_top.sv */
// Serial channel selector: shift register, pass-through and switch sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - One system clock times word loading and forward pass-through.
// - Chip select high: accept word bits, forward data toward second pin.
// - Chip select low: enable chosen channel, reverse data to first pin.
// - Chip select high: shift first data pin into 4-bit register each rising edge.
// - Word is one channel-on bit then three channel-number bits.
// - Channel-on bit one turns on the indexed channel.
// - Channel-on bit zero keeps every channel off.
// - Index is unsigned binary, msb first; 000 input zero, 111 input seven.
// - On chip select fall, all channels switch off at once.
// - After the gap and turn-on delay, chosen channel switches on.
// - Channel stays on until next chip select fall, then turns off.
// - Chip select high: forward driver on, reverse driver off.
// - Forward bits emerge on second pin after fourth rising edge.
// - Chip select low: first pin driven directly from second pin.
module smx_top (
  // System
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // Serial pins
  input wire logic ser_clk_i,
  input wire logic chip_sel_i,
  input wire logic data1_i,
  output logic data1_o,
  output logic data1_oe,
  input wire logic data2_i,
  output logic data2_o,
  output logic data2_oe,
  // Analog switch controls, channel status and buffer room
  output logic [smx_pkg::N_CHAN-1:0] analog_inputs,
  output logic chan_active,
  output logic word_room
);
  import smx_pkg::*;

  // Synchronised pins
  logic sclk_lvl;
  logic sclk_rise;
  logic cs_hi;
  logic cs_fall;
  logic d1_lvl;

  smx_sync3 #(.RST_VAL(1'b0)) u_clk_sync (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_i(ser_clk_i),
    .level_q(sclk_lvl),
    .rise_q(sclk_rise),
    .fall_q()
  );

  smx_sync3 #(.RST_VAL(CS_HI_RST)) u_cs_sync (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_i(chip_sel_i),
    .level_q(cs_hi),
    .rise_q(),
    .fall_q(cs_fall)
  );

  smx_sync3 #(.RST_VAL(1'b0)) u_d1_sync (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_i(data1_i),
    .level_q(d1_lvl),
    .rise_q(),
    .fall_q()
  );

  // Shift register
  logic [WORD_W-1:0] shreg_q;
  logic [WORD_W-1:0] shreg_d;
  logic shift_en;

  assign shift_en = clk_en & cs_hi & sclk_rise;
  assign shreg_d = shift_en ? {shreg_q[WORD_W-2:0], d1_lvl} : shreg_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shreg_q <= SHREG_RST;
    end else begin
      shreg_q <= shreg_d;
    end
  end

  assign data2_o = shreg_q[WORD_W-1];

  // Driver enables
  logic fwd_oe_q;
  logic rev_oe_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fwd_oe_q <= CS_HI_RST;
      rev_oe_q <= ~CS_HI_RST;
    end else if (clk_en) begin
      fwd_oe_q <= cs_hi;
      rev_oe_q <= ~cs_hi;
    end
  end

  assign data2_oe = fwd_oe_q;
  assign data1_oe = rev_oe_q;
  assign data1_o = data2_i;

  // Word buffer between loader and sequencer
  smx_word_if w_in ();
  smx_word_if w_out ();
  logic room_q;

  assign w_in.valid = cs_fall;
  assign w_in.data = shreg_q;

  smx_fifo2 u_buf (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .in_w(w_in.snk),
    .out_w(w_out.src)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      room_q <= 1'b1;
    end else if (clk_en) begin
      room_q <= w_in.ready;
    end
  end

  assign word_room = room_q;

  // Switch sequencer
  smx_state_t state_q;
  smx_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [WORD_W-1:0] word_q;
  logic [N_CHAN-1:0] chan_q;
  logic [N_CHAN-1:0] chan_d;
  logic [N_CHAN-1:0] chan_dec;
  logic word_on;
  logic cnt_done;
  logic pop;
  logic act_q;

  assign w_out.ready = (state_q != ST_BREAK);
  assign pop = clk_en & w_out.valid & w_out.ready;
  assign word_on = word_q[ON_BIT];
  assign chan_dec = CHAN_ONE << word_q[IDX_MSB:0];
  assign cnt_done = (cnt_q == CNT_ZERO);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - CNT_ONE;
    unique case (state_q)
      ST_IDLE: begin
        if (pop) begin
          state_d = ST_BREAK;
          cnt_d = TURN_OFF_DELAY_LOAD;
        end
      end
      ST_BREAK: begin
        if (cnt_done) begin
          state_d = word_on ? ST_MAKE : ST_IDLE;
          cnt_d = TON_LOAD;
        end
      end
      ST_MAKE: begin
        if (pop) begin
          state_d = ST_BREAK;
          cnt_d = TURN_OFF_DELAY_LOAD;
        end else if (cnt_done) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (pop) begin
          state_d = ST_BREAK;
          cnt_d = TURN_OFF_DELAY_LOAD;
        end
      end
    endcase
  end

  assign chan_d = cs_fall ? CHAN_RST :
                  (state_q == ST_MAKE && cnt_done && !pop) ? chan_dec :
                  (state_q == ST_ON && !pop) ? chan_q : CHAN_RST;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      word_q <= SHREG_RST;
      chan_q <= CHAN_RST;
      act_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      act_q <= |chan_d;
      if (pop) begin
        word_q <= w_out.data;
      end
    end
  end

  assign analog_inputs = chan_q;
  assign chan_active = act_q;

  // Checks
  logic [CNT_W-1:0] mk_len_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mk_len_q <= CNT_ZERO;
    end else if (clk_en) begin
      mk_len_q <= (state_q == ST_MAKE) ? mk_len_q + CNT_ONE : CNT_ZERO;
    end
  end

  sequence s_cs_fall;
    cs_fall && clk_en;
  endsequence

  sequence s_make_end;
    clk_en && state_q == ST_MAKE && cnt_done && !pop && !cs_fall;
  endsequence

  property p_shift;
    @(posedge clock) disable iff (!arst_n)
      shift_en |=> shreg_q == {$past(shreg_q[WORD_W-2:0]), $past(d1_lvl)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register missed a bit");

  property p_hold;
    @(posedge clock) disable iff (!arst_n)
      (!cs_hi && clk_en) |=> $stable(shreg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("shift while deselected");

  property p_dirs;
    @(posedge clock) disable iff (!arst_n)
      clk_en |=> (data2_oe == $past(cs_hi)) && (data1_oe != data2_oe);
  endproperty
  a_dirs: assert property (p_dirs) else $error("driver enables wrong");

  property p_rev;
    @(posedge clock) disable iff (!arst_n)
      data1_oe |-> data1_o == data2_i;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse path not direct");

  property p_break;
    @(posedge clock) disable iff (!arst_n)
      s_cs_fall |=> analog_inputs == CHAN_RST && !chan_active;
  endproperty
  a_break: assert property (p_break) else $error("channel on after select fall");

  property p_make;
    @(posedge clock) disable iff (!arst_n)
      s_make_end |-> mk_len_q == TON_LOAD ##1 analog_inputs == chan_dec;
  endproperty
  a_make: assert property (p_make) else $error("turn-on delay wrong");

  property p_on;
    @(posedge clock) disable iff (!arst_n)
      chan_active |-> word_on && analog_inputs == chan_dec;
  endproperty
  a_on: assert property (p_on) else $error("wrong channel on");

  property p_off;
    @(posedge clock) disable iff (!arst_n)
      (state_q == ST_IDLE || state_q == ST_BREAK) |-> analog_inputs == CHAN_RST;
  endproperty
  a_off: assert property (p_off) else $error("channel on while off");

  property p_d2;
    @(posedge clock) disable iff (!arst_n)
      $changed(data2_o) |-> $past(shift_en);
  endproperty
  a_d2: assert property (p_d2) else $error("second pin changed off edge");
endmodule // smx_top
`default_nettype wire

/* tb/smx_host_model.sv */
// Host serial port and chained converter model
`timescale 1ns/1ps
`default_nettype none
module smx_host_model (
  // Clock
  input wire logic clock,
  // Host side
  output logic ser_clk,
  output logic chip_sel,
  output logic host_d,
  output logic host_oe,
  // Converter side
  output logic conv_d,
  output logic conv_oe
);
  localparam int HALF = 6;
  initial begin
    ser_clk = 1'b0;
    chip_sel = 1'b1;
    host_d = 1'b0;
    host_oe = 1'b1;
    conv_d = 1'b0;
    conv_oe = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic one_bit(input logic b);
    host_d = b;
    idle(HALF);
    ser_clk = 1'b1;
    idle(HALF);
    ser_clk = 1'b0;
  endtask
  // Converter lets go before select rises
  task automatic open_frame;
    conv_oe = 1'b0;
    chip_sel = 1'b1;
    idle(HALF);
    host_oe = 1'b1;
  endtask
  task automatic apply;
    idle(HALF);
    chip_sel = 1'b0;
    host_oe = 1'b0;
  endtask
  // on bit, then index msb first
  task automatic send_word(input logic [3:0] w);
    open_frame();
    for (int i = 3; i >= 0; i--) begin
      one_bit(w[i]);
    end
    apply();
  endtask
  task automatic reverse(input logic b);
    conv_d = b;
    conv_oe = 1'b1;
  endtask
endmodule // smx_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the serial channel selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smx_pkg::*;
  localparam int LIMIT = 6000;
  logic clock;
  logic arst_n;
  logic clk_en;
  logic float_q = 1'b0;
  logic ser_clk, chip_sel, host_d, host_oe, conv_d, conv_oe;
  logic data1_o, data1_oe, data2_o, data2_oe, chan_active, word_room;
  logic [N_CHAN-1:0] analog_inputs;
  wire logic d1_wire;
  wire logic d2_wire;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // Released lines toggle instead of holding
  always @(posedge clock) float_q <= ~float_q;
  assign d1_wire = data1_oe ? data1_o : (host_oe ? host_d : float_q);
  assign d2_wire = data2_oe ? data2_o : (conv_oe ? conv_d : float_q);
  smx_top u_smx_top (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .ser_clk_i(ser_clk),
    .chip_sel_i(chip_sel), .data1_i(d1_wire), .data1_o(data1_o), .data1_oe(data1_oe),
    .data2_i(d2_wire), .data2_o(data2_o), .data2_oe(data2_oe),
    .analog_inputs(analog_inputs), .chan_active(chan_active), .word_room(word_room));
  smx_host_model u_smx_host_model (.clock(clock), .ser_clk(ser_clk), .chip_sel(chip_sel),
    .host_d(host_d), .host_oe(host_oe), .conv_d(conv_d), .conv_oe(conv_oe));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic test_reset;
    check(data2_oe, 1'b1, "oe2 reset");
    check(data1_oe, 1'b0, "oe1 reset");
    check(analog_inputs, 8'h00, "sw reset");
    check(chan_active, 1'b0, "active reset");
    check(data2_o, 1'b0, "d2 reset");
    check(word_room, 1'b1, "room reset");
    $display("test_reset done");
  endtask
  task automatic test_channels;
    int n;
    for (int i = 0; i < N_CHAN; i++) begin
      u_smx_host_model.send_word({1'b1, 3'(i)});
      repeat (10) @(negedge clock);
      check(analog_inputs, 8'h00, "break");
      n = 10;
      while (chan_active !== 1'b1 && n < 400) begin
        @(negedge clock);
        n++;
      end
      check(n >= TURN_OFF_DELAY_CYC + TON_CYC && n <= TURN_OFF_DELAY_CYC + TON_CYC + 12, 1'b1, "delay");
      check(analog_inputs, CHAN_ONE << i, "one hot");
    end
    $display("test_channels done");
  endtask
  task automatic test_forward;
    logic [7:0] pat;
    pat = 8'h5a;
    u_smx_host_model.open_frame();
    check(data2_oe, 1'b1, "fwd oe");
    check(data1_oe, 1'b0, "rev oe");
    check(analog_inputs, 8'h80, "held");
    for (int i = 7; i >= 0; i--) begin
      u_smx_host_model.one_bit(pat[i]);
      if (i <= 4) check(data2_o, pat[i + 3], "pass");
    end
    u_smx_host_model.apply();
    repeat (200) @(negedge clock);
    check(analog_inputs, 8'h04, "last word");
    $display("test_forward done");
  endtask
  task automatic test_reverse;
    check(data1_oe, 1'b1, "rev oe");
    check(data2_oe, 1'b0, "fwd off");
    u_smx_host_model.reverse(1'b1);
    #1;
    check(d1_wire, 1'b1, "rev hi");
    @(negedge clock);
    u_smx_host_model.reverse(1'b0);
    #1;
    check(d1_wire, 1'b0, "rev lo");
    @(negedge clock);
    $display("test_reverse done");
  endtask
  task automatic test_freeze;
    int n;
    u_smx_host_model.send_word(4'h9);
    repeat (20) @(negedge clock);
    clk_en = 1'b0;
    repeat (100) @(negedge clock);
    check(analog_inputs, 8'h00, "frozen");
    clk_en = 1'b1;
    n = 120;
    while (chan_active !== 1'b1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    check(n >= TURN_OFF_DELAY_CYC + TON_CYC + 100 && n <= TURN_OFF_DELAY_CYC + TON_CYC + 112, 1'b1, "freeze");
    check(analog_inputs, 8'h02, "after freeze");
    $display("test_freeze done");
  endtask
  task automatic test_off;
    logic [7:0] seen;
    seen = 8'h00;
    u_smx_host_model.send_word(4'hd);
    repeat (10) @(negedge clock);
    u_smx_host_model.send_word(4'h5);
    repeat (300) begin
      @(negedge clock);
      seen = seen | analog_inputs;
    end
    check(seen, 8'h00, "all off");
    $display("test_off done");
  endtask
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    test_reset();
    test_channels();
    test_forward();
    test_reverse();
    test_freeze();
    test_off();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
